/* File: design/adcdm_pkg.sv */
// Constants, register map and state encoding of the converter control block
package adcdm_pkg;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int SAMPLE_W  = 8;
  localparam int LEVEL_W   = 9;
  localparam int CNT_W     = 24;
  localparam int REQ_W     = 8;
  localparam int INT_W     = 3;
  localparam int PIN_W     = 6;

  localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] REG_FS_ADJ   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_INT_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_STATE    = 8'h10;

  localparam int CTRL_DDR_BIT      = 0;
  localparam int INT_CAL_START_BIT = 0;
  localparam int INT_CAL_DONE_BIT  = 1;
  localparam int INT_OOR_BIT       = 2;

  localparam logic                CTRL_DDR_RST  = 1'b0;
  localparam logic [SAMPLE_W-1:0] FS_ADJ_RST    = 8'h7f;
  localparam logic [SAMPLE_W-1:0] FS_LOW_LIMIT  = 8'h60;
  localparam logic [SAMPLE_W-1:0] FS_HIGH_LIMIT = 8'h7f;
  localparam logic [SAMPLE_W-1:0] OFFSET_FLIP   = 8'h80;
  localparam logic [INT_W-1:0]    INT_MASK_RST  = 3'h0;

  localparam logic [CNT_W-1:0] PUP_SHORT_CYCLES = 24'h000100;
  localparam logic [REQ_W-1:0] CAL_LOW_MIN      = 8'h50;
  localparam logic [REQ_W-1:0] CAL_HIGH_MIN     = 8'h50;

  typedef enum logic [2:0] {
    ST_PWRUP = 3'b001,
    ST_CAL   = 3'b010,
    ST_RUN   = 3'b100
  } adcdm_state_t;
endpackage

/* File: design/adcdm_top.sv */
// Converter control: calibration sequencing, sampling, demux, data clock
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ns
module adcdm_top
  import adcdm_pkg::*;
#(
  parameter logic [CNT_W-1:0] P_PUP_LONG_CYCLES = 24'h800000,
  parameter logic [CNT_W-1:0] P_CAL_CYCLES      = 24'h008000
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_conv_clk,
  input  wire logic [LEVEL_W-1:0]  i_analog_level,
  input  wire logic                i_fsr_level,
  input  wire logic                i_fsr_float,
  input  wire logic                i_power_up_calibration_delay_select_cs,
  input  wire logic                i_cal_req,
  input  wire logic                i_cmo_grounded,
  input  wire logic [ADDR_W-1:0]   i_addr,
  input  wire logic [DATA_W-1:0]   i_wr_data,
  input  wire logic                i_wr_en,
  input  wire logic                i_rd_en,
  output logic      [DATA_W-1:0]   o_rd_data,
  output logic                     o_irq,
  output logic                     o_calibration_running,
  output logic                     o_forwarded_data_clock,
  output logic      [SAMPLE_W-1:0] o_later_sample_bus,
  output logic      [SAMPLE_W-1:0] o_earlier_sample_bus,
  output logic                     o_out_of_range,
  output logic                     o_serial_chip_select,
  output logic                     o_common_mode_output_en
);

  // Two-stage synchronisers for pins and analog level
  logic [PIN_W-1:0]   pin_s1_r;
  logic [PIN_W-1:0]   pin_s2_r;
  logic [LEVEL_W-1:0] lvl_s1_r;
  logic [LEVEL_W-1:0] lvl_s2_r;
  logic               clk_d_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      lvl_s1_r <= '0;
      lvl_s2_r <= '0;
      clk_d_r  <= 1'b0;
    end else begin
      pin_s1_r <= {i_conv_clk, i_fsr_level, i_fsr_float,
                   i_power_up_calibration_delay_select_cs, i_cal_req, i_cmo_grounded};
      pin_s2_r <= pin_s1_r;
      lvl_s1_r <= i_analog_level;
      lvl_s2_r <= lvl_s1_r;
      clk_d_r  <= pin_s2_r[5];
    end
  end

  wire conv_clk_s = pin_s2_r[5];
  wire fsr_lvl_s  = pin_s2_r[4];
  wire fsr_flt_s  = pin_s2_r[3];
  wire power_up_calibration_delay_select_s   = pin_s2_r[2];
  wire cal_req_s  = pin_s2_r[1];
  wire cmo_gnd_s  = pin_s2_r[0];

  // Sample instant: falling edge of converter clock
  wire conv_fall  = clk_d_r & ~conv_clk_s;

  // Mode decode of the dual-use pin
  wire ecm         = fsr_flt_s;
  wire power_up_calibration_delay_select_long = ~ecm & power_up_calibration_delay_select_s;
  wire cs_active   = ecm & power_up_calibration_delay_select_s;
  wire [CNT_W-1:0] pup_target = power_up_calibration_delay_select_long ? P_PUP_LONG_CYCLES
                                            : PUP_SHORT_CYCLES;

  // Register file storage
  logic                ddr_r;
  logic [SAMPLE_W-1:0] fs_adj_r;
  logic [INT_W-1:0]    int_stat_r;
  logic [INT_W-1:0]    int_mask_r;

  // Calibration sequencer
  adcdm_state_t     state_r;
  adcdm_state_t     state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [REQ_W-1:0] low_cnt_r;
  logic [REQ_W-1:0] high_cnt_r;

  wire low_ok  = (low_cnt_r == CAL_LOW_MIN);
  wire high_ok = (high_cnt_r == CAL_HIGH_MIN);
  wire cal_go  = (state_r == ST_RUN) & low_ok & high_ok;
  wire [CNT_W-1:0] cnt_inc = conv_fall ? cnt_r + 24'h000001 : cnt_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_PWRUP: begin
        cnt_nxt = cnt_inc;
        if (cnt_r >= pup_target) begin
          state_nxt = ST_CAL;
          cnt_nxt   = '0;
        end
      end
      ST_CAL: begin
        cnt_nxt = cnt_inc;
        if (cnt_r >= P_CAL_CYCLES) begin
          state_nxt = ST_RUN;
          cnt_nxt   = '0;
        end
      end
      ST_RUN: begin
        cnt_nxt = '0;
        if (cal_go) begin
          state_nxt = ST_CAL;
        end
      end
      default: begin
        state_nxt = ST_PWRUP;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_PWRUP;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Request pin qualifier, counted in converter clock cycles
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_cnt_r  <= '0;
      high_cnt_r <= '0;
    end else if (state_r != ST_RUN) begin
      low_cnt_r  <= '0;
      high_cnt_r <= '0;
    end else if (conv_fall && !cal_req_s) begin
      low_cnt_r  <= low_ok ? low_cnt_r : low_cnt_r + 8'h01;
      high_cnt_r <= '0;
    end else if (conv_fall && low_ok && !high_ok) begin
      high_cnt_r <= high_cnt_r + 8'h01;
    end
  end

  // Full-scale limit and sample conversion
  wire [SAMPLE_W-1:0] fs_lim = ecm ? fs_adj_r
                                   : (fsr_lvl_s ? FS_HIGH_LIMIT
                                                : FS_LOW_LIMIT);
  wire signed [LEVEL_W-1:0] lvl    = lvl_s2_r;
  wire signed [LEVEL_W-1:0] pos_lim = {1'b0, fs_lim};
  wire signed [LEVEL_W-1:0] neg_lim = -pos_lim - 9'sd1;
  wire above = lvl > pos_lim;
  wire below = lvl < neg_lim;
  wire oor_now = above | below;
  wire signed [LEVEL_W-1:0] clip = above ? pos_lim
                                         : (below ? neg_lim : lvl);
  wire [SAMPLE_W-1:0] code = clip[SAMPLE_W-1:0] ^ OFFSET_FLIP;

  wire run_sample = conv_fall & (state_r == ST_RUN);

  // Demultiplexer and data clock
  logic                phase_r;
  logic [SAMPLE_W-1:0] hold_r;
  logic [SAMPLE_W-1:0] later_r;
  logic [SAMPLE_W-1:0] earlier_r;
  logic                forwarded_data_clock_r;
  logic                oor_r;

  wire pair_evt   = run_sample & phase_r;
  wire forwarded_data_clock_tog   = ddr_r ? pair_evt : run_sample;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_r <= 1'b0;
      hold_r  <= '0;
    end else if (state_r != ST_RUN) begin
      phase_r <= 1'b0;
    end else if (run_sample) begin
      phase_r <= ~phase_r;
      hold_r  <= phase_r ? hold_r : code;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      later_r   <= '0;
      earlier_r <= '0;
    end else if (pair_evt) begin
      later_r   <= code;
      earlier_r <= hold_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      forwarded_data_clock_r <= 1'b0;
      oor_r  <= 1'b0;
    end else begin
      // Parks low from the very edge at which calibration begins
      if (state_nxt != ST_RUN) begin
        forwarded_data_clock_r <= 1'b0;
      end else if (forwarded_data_clock_tog) begin
        forwarded_data_clock_r <= ~forwarded_data_clock_r;
      end
      if (run_sample) begin
        oor_r <= oor_now;
      end
    end
  end

  // Register bus decode
  wire wr_ctrl  = i_wr_en & (i_addr == REG_CTRL);
  wire wr_fs    = i_wr_en & (i_addr == REG_FS_ADJ);
  wire wr_stat  = i_wr_en & (i_addr == REG_INT_STAT);
  wire wr_mask  = i_wr_en & (i_addr == REG_INT_MASK);

  wire cal_start_evt = (state_r != ST_CAL) & (state_nxt == ST_CAL);
  wire cal_done_evt  = (state_r == ST_CAL) & (state_nxt == ST_RUN);
  wire oor_evt       = run_sample & oor_now;

  logic [INT_W-1:0] int_set;
  always_comb begin
    int_set = '0;
    int_set[INT_CAL_START_BIT] = cal_start_evt;
    int_set[INT_CAL_DONE_BIT]  = cal_done_evt;
    int_set[INT_OOR_BIT]       = oor_evt;
  end

  wire [INT_W-1:0] int_clr  = wr_stat ? i_wr_data[INT_W-1:0] : '0;
  wire [INT_W-1:0] int_nxt  = (int_stat_r & ~int_clr) | int_set;
  wire             irq_nxt  = |(int_nxt & int_mask_r);

  wire [DATA_W-1:0] state_word = {28'h0000000, power_up_calibration_delay_select_long, cmo_gnd_s,
                                  ecm, state_r == ST_CAL};

  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    case (i_addr)
      REG_CTRL:     rd_mux = {31'h00000000, ddr_r};
      REG_FS_ADJ:   rd_mux = {24'h000000, fs_adj_r};
      REG_INT_STAT: rd_mux = {29'h00000000, int_stat_r};
      REG_INT_MASK: rd_mux = {29'h00000000, int_mask_r};
      REG_STATE:    rd_mux = state_word;
      default:      rd_mux = '0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ddr_r      <= CTRL_DDR_RST;
      fs_adj_r   <= FS_ADJ_RST;
      int_mask_r <= INT_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ddr_r <= i_wr_data[CTRL_DDR_BIT];
      end
      if (wr_fs) begin
        fs_adj_r <= i_wr_data[SAMPLE_W-1:0];
      end
      if (wr_mask) begin
        int_mask_r <= i_wr_data[INT_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_stat_r <= '0;
      o_irq      <= 1'b0;
      o_rd_data  <= '0;
    end else begin
      int_stat_r <= int_nxt;
      o_irq      <= irq_nxt;
      o_rd_data  <= i_rd_en ? rd_mux : '0;
    end
  end

  // Registered pin outputs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_calibration_running   <= 1'b0;
      o_serial_chip_select    <= 1'b0;
      o_common_mode_output_en <= 1'b0;
    end else begin
      o_calibration_running   <= (state_nxt == ST_CAL);
      o_serial_chip_select    <= cs_active;
      o_common_mode_output_en <= ~cmo_gnd_s;
    end
  end

  assign o_forwarded_data_clock = forwarded_data_clock_r;
  assign o_later_sample_bus     = later_r;
  assign o_earlier_sample_bus   = earlier_r;
  assign o_out_of_range         = oor_r;

endmodule // adcdm_top

/* File: verif/adcdm_properties.sv */
// Checker of calibration, data clock and pin behaviour
`timescale 1ns/1ns
module adcdm_properties
  import adcdm_pkg::*;
(
  input wire logic                i_clk,
  input wire logic                i_rst_n,
  input wire logic                i_fsr_float,
  input wire logic                i_power_up_calibration_delay_select_cs,
  input wire logic                i_cmo_grounded,
  input wire logic                o_calibration_running,
  input wire logic                o_forwarded_data_clock,
  input wire logic [SAMPLE_W-1:0] o_later_sample_bus,
  input wire logic [SAMPLE_W-1:0] o_earlier_sample_bus,
  input wire logic                o_serial_chip_select,
  input wire logic                o_common_mode_output_en
);
  wire cal = o_calibration_running;
  wire dck = o_forwarded_data_clock;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  forwarded_data_clock_cal_stop_a: assert property (cal && $past(cal) |-> $stable(dck))
    else $error("data clock moved in calibration");
  bus_frozen_a: assert property (cal && $past(cal) |->
    $stable(o_later_sample_bus) && $stable(o_earlier_sample_bus))
    else $error("sample bus moved in calibration");
  forwarded_data_clock_rate_a: assert property ($changed(dck) |=> ($stable(dck) || cal)[*8])
    else $error("data clock toggles too fast");
  cal_hold_a: assert property ($rose(cal) |=> cal[*8])
    else $error("calibration indicator dropped early");
  csel_on_a: assert property ((i_fsr_float && i_power_up_calibration_delay_select_cs)[*4] |=>
    o_serial_chip_select)
    else $error("chip select missing");
  csel_off_a: assert property ((!i_fsr_float)[*4] |=>
    !o_serial_chip_select)
    else $error("chip select in normal mode");
  cmo_ac_a: assert property (i_cmo_grounded[*4] |=>
    !o_common_mode_output_en)
    else $error("common mode driven in ac mode");
  cmo_dc_a: assert property ((!i_cmo_grounded)[*4] |=>
    o_common_mode_output_en)
    else $error("common mode not driven");
endmodule // adcdm_properties

bind adcdm_top adcdm_properties u_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_fsr_float(i_fsr_float),
  .i_power_up_calibration_delay_select_cs(i_power_up_calibration_delay_select_cs), .i_cmo_grounded(i_cmo_grounded),
  .o_calibration_running(o_calibration_running),
  .o_forwarded_data_clock(o_forwarded_data_clock),
  .o_later_sample_bus(o_later_sample_bus),
  .o_earlier_sample_bus(o_earlier_sample_bus),
  .o_serial_chip_select(o_serial_chip_select),
  .o_common_mode_output_en(o_common_mode_output_en)
);

/* File: verif/adcdm_rx.sv */
// Receiver model capturing sample pairs at data clock edges
`timescale 1ns/1ns
module adcdm_rx
  import adcdm_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_forwarded_data_clock,
  input  wire logic                i_cal_running,
  input  wire logic [SAMPLE_W-1:0] i_early,
  input  wire logic [SAMPLE_W-1:0] i_late,
  output logic                     o_cap,
  output logic      [15:0]         o_pair,
  output int                       o_tog
);
  logic forwarded_data_clock_r;
  wire  edge_seen = i_forwarded_data_clock != forwarded_data_clock_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      forwarded_data_clock_r <= 1'b0;
      o_cap  <= 1'b0;
      o_pair <= 16'h0000;
      o_tog  <= 0;
    end else begin
      forwarded_data_clock_r <= i_forwarded_data_clock;
      o_cap  <= edge_seen && !i_cal_running;
      o_tog  <= o_tog + int'(edge_seen);
      if (edge_seen)
        o_pair <= {i_early, i_late};
    end
  end
endmodule // adcdm_rx

/* File: verif/adcdm_top_tb.sv */
// Self-checking testbench of the converter control block
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module adcdm_top_tb
  import adcdm_pkg::*;
;
  localparam logic [CNT_W-1:0] LONG = 24'h000040;
  localparam logic [CNT_W-1:0] CALN = 24'h000020;
  logic clk = 1'b0, rst_n = 1'b0, cck = 1'b0;
  logic [8:0] lvl = 9'h000;
  logic fl = 1'b1, ff = 1'b0, cs = 1'b1, cr = 1'b1, gnd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, rv;
  logic we = 1'b0, re = 1'b0, ddr = 1'b0;
  wire [31:0] rdd;
  wire irq, cal, dck, oor, csel, cmoe, cap;
  wire [7:0] late, early;
  wire [15:0] pr;
  int tog, err_count = 0, n_tests = 0, seed = 46, nf = 0, lim = 127;
  int t0, t1, k;
  logic [8:0] hist[$];

  adcdm_top #(.P_PUP_LONG_CYCLES(LONG), .P_CAL_CYCLES(CALN)) dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_conv_clk(cck), .i_analog_level(lvl),
    .i_fsr_level(fl), .i_fsr_float(ff), .i_power_up_calibration_delay_select_cs(cs), .i_cal_req(cr),
    .i_cmo_grounded(gnd), .i_addr(addr), .i_wr_data(wd), .i_wr_en(we),
    .i_rd_en(re), .o_rd_data(rdd), .o_irq(irq),
    .o_calibration_running(cal), .o_forwarded_data_clock(dck),
    .o_later_sample_bus(late), .o_earlier_sample_bus(early),
    .o_out_of_range(oor), .o_serial_chip_select(csel),
    .o_common_mode_output_en(cmoe));
  adcdm_rx u_rx (.i_clk(clk), .i_rst_n(rst_n), .i_forwarded_data_clock(dck),
    .i_cal_running(cal), .i_early(early), .i_late(late), .o_cap(cap),
    .o_pair(pr), .o_tog(tog));

  initial forever #4 clk = ~clk;
  initial begin
    #3;
    forever begin
      #62 cck = 1'b1;
      #63 cck = 1'b0;
    end
  end
  always @(posedge cck) begin
    @(posedge clk);
    lvl <= 9'($random(seed));
  end
  always @(negedge cck) begin
    hist.push_back({ovr(lvl), code(lvl)});
    nf++;
  end

  function automatic logic [7:0] code(logic [8:0] v);
    int s;
    s = $signed(v);
    if (s > lim) s = lim;
    if (s < -lim - 1) s = -lim - 1;
    return s[7:0] ^ 8'h80;
  endfunction
  function automatic logic ovr(logic [8:0] v);
    return $signed(v) > lim || $signed(v) < -lim - 1;
  endfunction

  always @(posedge clk) if (cap === 1'b1 && rst_n) begin
    `CHK("oor", hist[nf-1][8], oor)
    if (ddr) begin
      `CHK("later", hist[nf-1][7:0], pr[7:0])
      `CHK("earlier", hist[nf-2][7:0], pr[15:8])
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, string n);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 `CHK(n, e, rdd)
  endtask
  task automatic wcal(logic v);
    k = 0;
    while (cal !== v && k < 20000) begin
      @(posedge clk);
      k++;
    end
    if (k == 20000) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic rate(int n);
    @(posedge cck);
    t0 = tog;
    repeat (n) @(posedge cck);
    t1 = tog - t0;
  endtask
  task automatic setr(logic l, logic f, int m);
    @(posedge cck);
    repeat (2) @(posedge clk);
    fl <= l;
    ff <= f;
    lim = m;
  endtask
  task automatic irq_is(logic e);
    repeat (3) @(posedge clk);
    `CHK("irq", e, irq)
  endtask

  initial begin
    repeat (6) @(posedge clk);
    `CHK("cal in reset", 1'b0, cal)
    rst_n <= 1'b1;
    t0 = nf;
    rd(REG_CTRL, 32'h0, "ctrl");
    rd(REG_FS_ADJ, 32'h7f, "fs adj");
    rd(REG_INT_MASK, 32'h0, "mask");
    rd(8'h14, 32'h0, "unmapped");
    rd(REG_STATE, 32'h8, "state long");
    `CHK("cmo en", 1'b1, cmoe)
    `CHK("csel off", 1'b0, csel)
    wcal(1'b1);
    `CHK("pup long", LONG, nf - t0)
    t0 = nf;
    wcal(1'b0);
    `CHK("cal length", CALN, nf - t0)
    $display("power-up test done");
    rate(16);
    `CHK("sdr rate", 16, t1)
    wr(REG_CTRL, 32'h1);
    rate(16);
    `CHK("ddr rate", 8, t1)
    ddr = 1'b1;
    repeat (40) @(negedge cck);
    setr(1'b0, 1'b0, 96);
    repeat (40) @(negedge cck);
    wr(REG_FS_ADJ, 32'h40);
    setr(1'b0, 1'b1, 64);
    repeat (40) @(negedge cck);
    rd(REG_STATE, 32'h2, "state ext");
    `CHK("csel on", 1'b1, csel)
    @(posedge clk);
    cs <= 1'b0;
    $display("range test done");
    wr(REG_INT_MASK, 32'h3);
    wr(REG_INT_STAT, 32'h7);
    irq_is(1'b0);
    cr <= 1'b0;
    repeat (82) @(negedge cck);
    @(posedge clk);
    cr <= 1'b1;
    t0 = nf;
    wcal(1'b1);
    `CHK("req wait", 1'b1, nf - t0 >= 80 && nf - t0 <= 82)
    irq_is(1'b1);
    wr(REG_INT_MASK, 32'h0);
    irq_is(1'b0);
    wr(REG_INT_MASK, 32'h3);
    wr(REG_INT_STAT, 32'h3);
    irq_is(1'b0);
    wcal(1'b0);
    irq_is(1'b1);
    repeat (40) @(negedge cck);
    $display("calibration request test done");
    @(posedge clk);
    rst_n <= 1'b0;
    gnd <= 1'b1;
    cs <= 1'b1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t0 = nf;
    ddr = 1'b0;
    lim = 127;
    repeat (4) @(posedge clk);
    rd(REG_STATE, 32'h6, "state short");
    `CHK("cmo off", 1'b0, cmoe)
    `CHK("csel ext", 1'b1, csel)
    wcal(1'b1);
    `CHK("pup short", PUP_SHORT_CYCLES, nf - t0)
    wcal(1'b0);
    $display("second reset test done");
    wrap_up();
  end
endmodule // adcdm_top_tb
